// ==== verilog/mac_tx_map.vh ====
// Constants for the transmit bus and pause generator: sizes, levels and register map.
`ifndef MAC_TX_MAP_VH
`define MAC_TX_MAP_VH
`define SEG_COUNT      4
`define SEG_W          128
`define BUF_DEPTH      7'h0020
`define BUF_AW         5
`define RDY_LEVEL      7'h0008
`define SAFE_WRITES    3'h4
`define SEG_BYTES      14'h0010
`define MIN_PKT_BYTES  14'h0040
`define PAUSE_SEGS     2'h3
`define CLASS_GLOBAL   8
`define MASK_GLOBAL    9'h100
`define QUANTA_W       16
`define CRC_INIT       32'hFFFF_FFFF
`define CRC_POLY       32'hEDB8_8320
`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_SMALLCNT  8'h08
`define CTRL_RESET     1'b1
`endif

// ==== verilog/mac_tx_bus_and_pause_gen.v ====
// Transmit bus intake, line buffer, undersize check and pause frame generator with APB access.
//
// Notes on behaviour
// R01 - Source gives empty-byte count zero for full end segment, else 1 to 15.
// R02 - Packets under 64 bytes raise the undersized pulse; source must avoid them.
// R03 - An end and a new start may sit in adjacent segments of one cycle.
// R04 - Mid-packet fully idle cycles are only allowed while ready is low.
// R05 - Data in the first cycle with ready low is taken without overflow.
// R06 - Source should stop writing after that until ready returns.
// R07 - Source never places two start markers in one cycle.
// R08 - Source closes each packet before starting the next one.
// R09 - Source never idles mid-packet while ready is high.
// R10 - No idle segment between active ones unless the earlier carries an end; the intake stores segment k at wptr_q + k, so even that gap is not handled.
// R11 - Source should not write after four or more cycles of ready low.
// R12 - After overflow the source stops writing and resets the device.
// R13 - Pause request and enable are 9 bits; bit 8 global, bits 7..0 priorities.
// R14 - Each pause request and enable bit stays stable at least 16 cycles.
// R15 - Global and priority pause are never requested together.
// R16 - Frames are built from separate global and priority address, type, opcode, quanta.
// R17 - Device appends the FCS and builds the class-enable vector for priority frames.
// R18 - Request active only while request and enable are both one; else cancelled.
// R19 - A requested pause frame goes out once the in-flight packet completes.
// R20 - Nine refresh timers reload after sending and resend on expiry.
// R21 - A one-cycle resend pulse forces every timer to zero.
// R22 - Any priority expiry expires all running; pending work merges into one frame.
// R23 - Four writes are safe after ready falls; beyond that overflow is flagged.
// R24 - Segment 0 is active whenever data moves; segments fill upward in order.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "mac_tx_map.vh"

module mac_tx_bus_and_pause_gen (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    input  wire [511:0] seg_data,
    input  wire [3:0]   seg_ena,
    input  wire [3:0]   seg_sop,
    input  wire [3:0]   seg_eop,
    input  wire [3:0]   seg_err,
    input  wire [15:0]  seg_mty,
    output reg          seg_rdy,
    output reg          seg_ovf,
    output reg          packet_small,
    input  wire [8:0]   pause_req,
    input  wire [8:0]   pause_en,
    input  wire [47:0]  global_frame_dest_addr,
    input  wire [47:0]  global_frame_src_addr,
    input  wire [15:0]  global_frame_ethertype,
    input  wire [15:0]  global_frame_opcode,
    input  wire [15:0]  global_quanta_value,
    input  wire [47:0]  priority_frame_dest_addr,
    input  wire [47:0]  priority_frame_src_addr,
    input  wire [15:0]  priority_frame_ethertype,
    input  wire [15:0]  priority_frame_opcode,
    input  wire [15:0]  prio0_quanta_value,
    input  wire [15:0]  prio1_quanta_value,
    input  wire [15:0]  prio2_quanta_value,
    input  wire [15:0]  prio3_quanta_value,
    input  wire [15:0]  prio4_quanta_value,
    input  wire [15:0]  prio5_quanta_value,
    input  wire [15:0]  prio6_quanta_value,
    input  wire [15:0]  prio7_quanta_value,
    input  wire [143:0] pause_refresh_interval,
    input  wire         force_pause_resend,
    output reg  [127:0] line_data,
    output reg          line_valid,
    output reg          line_sop,
    output reg          line_eop,
    output reg  [3:0]   line_mty,
    output reg          line_err
);

    localparam P_IDLE = 1'b0;
    localparam P_SEND = 1'b1;

    // Buffer entry: {err, sop, eop, mty[3:0], data[127:0]}.
    reg  [134:0] buf_mem [0:31];
    reg  [4:0]   wptr_q;
    reg  [4:0]   rptr_q;
    reg  [6:0]   count_q;
    reg  [2:0]   lowwr_q;
    reg  [13:0]  len_q;
    reg  [15:0]  small_cnt_q;
    reg          ctrl_en_q;
    reg          out_pkt_q;
    reg          pstate_q;
    reg  [1:0]   pseg_q;
    reg  [8:0]   smask_q;
    reg  [8:0]   pend_q;
    reg  [8:0]   run_q;
    reg  [8:0]   act_q;
    reg  [143:0] tmr_q;

    // Ethernet CRC over the 60 header and payload bytes, least significant bit of each byte first.
    function [31:0] crc60;
        input [479:0] b;
        integer i;
        reg [31:0] c;
        reg        fb;
        begin
            c = `CRC_INIT;
            for (i = 0; i < 480; i = i + 1) begin
                fb = c[0] ^ b[472 - 8 * (i / 8) + (i % 8)];
                c = (c >> 1) ^ (fb ? `CRC_POLY : 32'h0000_0000);
            end
            crc60 = ~c;
        end
    endfunction

    // Intake: count segments, check overflow, track packet length for the undersize flag.
    reg  [2:0]   nwr;
    reg          wr_cyc;
    reg          ovf_hit;
    reg          wr_ok;
    reg          small_hit;
    reg  [13:0]  len_d;
    integer      k;
    always @* begin
        nwr = 3'h0;
        small_hit = 1'b0;
        len_d = len_q;
        for (k = 0; k < `SEG_COUNT; k = k + 1) begin
            if (seg_ena[k]) begin
                nwr = nwr + 3'h1; // [R24]
                if (seg_sop[k]) begin
                    len_d = 14'h0000; // [R03]
                end
                if (seg_eop[k]) begin
                    len_d = len_d + `SEG_BYTES - {10'h000, seg_mty[4*k +: 4]}; // [R01]
                    if (len_d < `MIN_PKT_BYTES) begin
                        small_hit = 1'b1; // [R02]
                    end
                    len_d = 14'h0000;
                end else begin
                    len_d = len_d + `SEG_BYTES;
                end
            end
        end
        wr_cyc = (nwr != 3'h0);
        // Space loss or a fifth write under back-pressure both count as violations.
        ovf_hit = wr_cyc && ((count_q + {4'h0, nwr} > `BUF_DEPTH) ||
                             (!seg_rdy && (lowwr_q >= `SAFE_WRITES))); // [R23]
        wr_ok = wr_cyc && !ovf_hit && !seg_ovf; // [R05]
    end

    // Pause request bookkeeping: activity, rising requests, expiries and merging.
    wire [8:0] act = pause_req & pause_en; // [R13] [R18]
    wire [8:0] rise = act & ~act_q;
    reg  [8:0] expd;
    integer    t;
    always @* begin
        for (t = 0; t < 9; t = t + 1) begin
            expd[t] = run_q[t] && (tmr_q[16*t +: 16] == 16'h0000);
        end
    end
    // Any priority event pulls every running priority timer into the same frame.
    wire       prio_evt = |(expd[7:0] | rise[7:0]); // [R22]
    wire [8:0] merge = {1'b0, prio_evt ? run_q[7:0] : 8'h00}; // [R22]
    wire [8:0] pend_all = (pend_q | rise | expd | merge) & act; // [R18] [R20]

    // A pause frame may only start on a packet boundary of the line.
    wire pause_go = (pstate_q == P_IDLE) && !out_pkt_q && (pend_q != 9'h000); // [R19]
    wire [8:0] go_mask = pend_q[`CLASS_GLOBAL] ? `MASK_GLOBAL : {1'b0, pend_q[7:0]};
    wire [134:0] head = buf_mem[rptr_q];
    wire rd = ctrl_en_q && (count_q != 7'h00) && (pstate_q == P_IDLE) && !pause_go;
    wire p_last = (pstate_q == P_SEND) && (pseg_q == `PAUSE_SEGS);

    // Frame body for the latched classes, followed by its FCS.
    wire [479:0] body_g = {global_frame_dest_addr, global_frame_src_addr,
                           global_frame_ethertype, global_frame_opcode,
                           global_quanta_value, 336'h0};
    wire [479:0] body_p = {priority_frame_dest_addr, priority_frame_src_addr,
                           priority_frame_ethertype, priority_frame_opcode,
                           8'h00, smask_q[7:0], // [R17]
                           {16{smask_q[0]}} & prio0_quanta_value,
                           {16{smask_q[1]}} & prio1_quanta_value,
                           {16{smask_q[2]}} & prio2_quanta_value,
                           {16{smask_q[3]}} & prio3_quanta_value,
                           {16{smask_q[4]}} & prio4_quanta_value,
                           {16{smask_q[5]}} & prio5_quanta_value,
                           {16{smask_q[6]}} & prio6_quanta_value,
                           {16{smask_q[7]}} & prio7_quanta_value,
                           208'h0}; // [R16]
    wire [479:0] body = smask_q[`CLASS_GLOBAL] ? body_g : body_p;
    wire [31:0]  fcs = crc60(body); // [R17]
    wire [511:0] frame = {body, fcs[7:0], fcs[15:8], fcs[23:16], fcs[31:24]};
    wire [511:0] frame_sh = frame << {pseg_q, 7'h00};

    // Buffer storage; data words need no reset, only pointers do.
    integer w;
    always @(posedge pclk) begin
        if (wr_ok) begin
            for (w = 0; w < `SEG_COUNT; w = w + 1) begin
                if (seg_ena[w]) begin
                    buf_mem[wptr_q + w[4:0]] <= {seg_err[w], seg_sop[w], seg_eop[w],
                                            seg_mty[4*w +: 4], seg_data[128*w +: 128]};
                end
            end
        end
    end

    // Pointers, fill level, back-pressure and the overflow flag.
    wire [6:0] count_d = count_q + (wr_ok ? {4'h0, nwr} : 7'h00) - {6'h00, rd};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= 5'h00;
            rptr_q <= 5'h00;
            count_q <= 7'h00;
            lowwr_q <= 3'h0;
            len_q <= 14'h0000;
            small_cnt_q <= 16'h0000;
            seg_rdy <= 1'b0;
            seg_ovf <= 1'b0;
            packet_small <= 1'b0;
        end else begin
            if (wr_ok) begin
                wptr_q <= wptr_q + {2'h0, nwr};
                len_q <= len_d;
            end
            if (rd) begin
                rptr_q <= rptr_q + 5'h01;
            end
            count_q <= count_d;
            // Ready leaves headroom for four full cycles of segments after it falls.
            seg_rdy <= (count_d <= `RDY_LEVEL); // [R23]
            if (seg_rdy) begin
                lowwr_q <= 3'h0;
            end else if (wr_cyc && (lowwr_q != 3'h7)) begin
                lowwr_q <= lowwr_q + 3'h1; // [R05]
            end
            // Sticky until reset; only a reset brings the bus back.
            if (ovf_hit) begin
                seg_ovf <= 1'b1; // [R23]
            end
            packet_small <= wr_ok && small_hit; // [R02]
            if (wr_ok && small_hit) begin
                small_cnt_q <= small_cnt_q + 16'h0001;
            end
        end
    end

    // Pause sequencing, pending mask and the nine refresh timers.
    integer j;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pstate_q <= P_IDLE;
            pseg_q <= 2'h0;
            smask_q <= 9'h000;
            pend_q <= 9'h000;
            run_q <= 9'h000;
            act_q <= 9'h000;
            tmr_q <= 144'h0;
        end else begin
            act_q <= act;
            pend_q <= pend_all & ~(pause_go ? go_mask : 9'h000); // [R22]
            case (pstate_q)
                P_IDLE: begin
                    if (pause_go) begin
                        pstate_q <= P_SEND; // [R19]
                        smask_q <= go_mask;
                        pseg_q <= 2'h0;
                    end
                end
                P_SEND: begin
                    pseg_q <= pseg_q + 2'h1;
                    if (p_last) begin
                        pstate_q <= P_IDLE;
                    end
                end
                default: begin
                    pstate_q <= P_IDLE;
                end
            endcase
            for (j = 0; j < 9; j = j + 1) begin
                if (!act[j]) begin
                    run_q[j] <= 1'b0; // [R18]
                end else if (p_last && smask_q[j]) begin
                    run_q[j] <= 1'b1; // [R20]
                    tmr_q[16*j +: 16] <= pause_refresh_interval[16*j +: 16];
                end else if (expd[j] || merge[j]) begin
                    run_q[j] <= 1'b0; // [R20]
                end else if (force_pause_resend) begin
                    tmr_q[16*j +: 16] <= 16'h0000; // [R21]
                end else if (run_q[j] && (tmr_q[16*j +: 16] != 16'h0000)) begin
                    tmr_q[16*j +: 16] <= tmr_q[16*j +: 16] - 16'h0001;
                end
            end
        end
    end

    // Line side: one segment per cycle from the buffer or from the pause frame.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pkt_q <= 1'b0;
            line_data <= 128'h0;
            line_valid <= 1'b0;
            line_sop <= 1'b0;
            line_eop <= 1'b0;
            line_mty <= 4'h0;
            line_err <= 1'b0;
        end else if (pstate_q == P_SEND) begin
            line_data <= frame_sh[511:384];
            line_valid <= 1'b1;
            line_sop <= (pseg_q == 2'h0);
            line_eop <= p_last;
            line_mty <= 4'h0;
            line_err <= 1'b0;
        end else if (rd) begin
            // Tracks a packet in flight so a pause frame never splits it.
            if (head[132]) begin
                out_pkt_q <= 1'b0; // [R19]
            end else if (head[133]) begin
                out_pkt_q <= 1'b1;
            end
            line_data <= head[127:0];
            line_valid <= 1'b1;
            line_sop <= head[133];
            line_eop <= head[132];
            line_mty <= head[131:128];
            line_err <= head[134] && head[132];
        end else begin
            line_valid <= 1'b0;
            line_sop <= 1'b0;
            line_eop <= 1'b0;
            line_err <= 1'b0;
        end
    end

    // APB slave: answer prepared in setup, completed in the single access cycle.
    reg [31:0] rdata_d;
    reg        hit_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (paddr)
            `ADDR_CTRL:     rdata_d = {31'h0, ctrl_en_q};
            `ADDR_STATUS:   rdata_d = {14'h0, pend_q, pstate_q, out_pkt_q, seg_ovf, count_q[5:0]};
            `ADDR_SMALLCNT: rdata_d = {16'h0000, small_cnt_q};
            default:        hit_d = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl_en_q <= `CTRL_RESET;
        end else begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !hit_d;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_d;
            end
            if (psel && penable && pready && pwrite && (paddr == `ADDR_CTRL)) begin
                ctrl_en_q <= pwdata[0];
            end
        end
    end

endmodule

// ==== dv/mac_tx_asserts.sv ====
// Concurrent checks on the ports of the transmit bus and pause generator.
`timescale 1ns/1ns
`include "mac_tx_map.vh"

module mac_tx_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  seg_ena,
    input wire [3:0]  seg_eop,
    input wire        seg_rdy,
    input wire        seg_ovf,
    input wire        packet_small,
    input wire        line_valid,
    input wire        line_sop,
    input wire        line_eop,
    input wire [3:0]  line_mty
);
    logic [2:0] wr_low_q;
    logic [2:0] wr_low_d;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Write cycles seen while ready is low; it saturates so a runaway source cannot wrap it.
    assign wr_low_d = seg_rdy ? 3'h0 :
                      ((|seg_ena && wr_low_q != 3'h7) ? wr_low_q + 3'h1 : wr_low_q);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_low_q <= 3'h0;
        end else begin
            wr_low_q <= wr_low_d;
        end
    end

    AST_APB_ANSWER: assert property (psel && !penable |=> pready && penable)
        else $error("no answer after setup");
    AST_APB_ACCESS: assert property (pready || pslverr |-> psel && penable && !$past(penable))
        else $error("answer outside access phase");
    AST_UNMAPPED: assert property (pready && paddr > `ADDR_SMALLCNT |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_SMALL_CAUSE: assert property (packet_small |-> |($past(seg_ena) & $past(seg_eop)))
        else $error("undersize flag without packet end");
    AST_MTY_ON_EOP: assert property (line_valid && !line_eop |-> line_mty == 4'h0)
        else $error("empty bytes on a middle segment");
    AST_LINE_QUAL: assert property (line_sop || line_eop |-> line_valid)
        else $error("marker without valid");
    AST_OVF_STICKY: assert property (seg_ovf |=> seg_ovf)
        else $error("overflow flag cleared");
    AST_OVF_FIFTH: assert property (!seg_rdy && |seg_ena && wr_low_q == 3'h4 |=> seg_ovf)
        else $error("fifth late write not flagged");
    AST_NO_EARLY_OVF: assert property (!seg_rdy && |seg_ena && wr_low_q < 3'h4 && !seg_ovf
        |=> !seg_ovf)
        else $error("overflow on an allowed write");

    COV_SMALL: cover property (packet_small);
    COV_OVF: cover property ($rose(seg_ovf));
    COV_FRAME: cover property (line_sop ##3 line_eop);
endmodule

bind mac_tx_bus_and_pause_gen mac_tx_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seg_ena(seg_ena), .seg_eop(seg_eop), .seg_rdy(seg_rdy),
    .seg_ovf(seg_ovf), .packet_small(packet_small), .line_valid(line_valid),
    .line_sop(line_sop), .line_eop(line_eop), .line_mty(line_mty));

// ==== dv/seg_source.sv ====
// User transmit packet source that drives the segmented local bus.
`timescale 1ns/1ns

module seg_source (
    input  wire          pclk,
    input  wire          seg_rdy,
    output logic [511:0] seg_data,
    output logic [3:0]   seg_ena,
    output logic [3:0]   seg_sop,
    output logic [3:0]   seg_eop,
    output logic [3:0]   seg_err,
    output logic [15:0]  seg_mty
);
    // Quiet bus at time zero; this source never marks a packet in error.
    initial begin
        seg_data = 512'h0;
        seg_ena = 4'h0;
        seg_sop = 4'h0;
        seg_eop = 4'h0;
        seg_err = 4'h0;
        seg_mty = 16'h0;
    end

    // One bus cycle, held until the next rising edge has sampled it.
    task automatic cyc(input logic [3:0] e, s, q, input logic [15:0] m);
        seg_ena <= e;
        seg_sop <= s;
        seg_eop <= q;
        seg_mty <= m;
        seg_data <= {32{16'ha5c3}};
        @(posedge pclk);
    endtask

    // Idle cycle; data flips so a stale value can never pass for a fresh one.
    task automatic idle();
        seg_ena <= 4'h0;
        seg_sop <= 4'h0;
        seg_eop <= 4'h0;
        seg_mty <= ~seg_mty;
        seg_data <= ~seg_data;
        @(posedge pclk);
    endtask

    // Whole packet from segment 0 upward: one start, no gaps, closed by an end.
    task automatic pkt(input int nbytes);
        int left;
        logic [3:0] e, s, q;
        logic [15:0] m;
        left = nbytes;
        s = 4'h1;
        while (left > 0) begin
            e = 4'h0;
            q = 4'h0;
            m = 16'h0;
            for (int k = 0; k < 4 && left > 0; k++) begin
                e[k] = 1'h1;
                q[k] = left <= 16;
                m[4*k+:4] = left < 16 ? 4'(16 - left) : 4'h0;
                left = left - 16;
            end
            while (!seg_rdy) idle();
            cyc(e, s, q, m);
            s = 4'h0;
        end
        idle();
    endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the transmit bus and pause generator.
`timescale 1ns/1ns
`include "mac_tx_map.vh"
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %0t: %s", $time, m); end end

module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, force_pause_resend, err;
    logic seg_rdy, seg_ovf, packet_small, line_valid, line_sop, line_eop, line_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [511:0] seg_data;
    logic [3:0] seg_ena, seg_sop, seg_eop, seg_err, line_mty, lmty;
    logic [15:0] seg_mty, gty, gop, q [0:8];
    logic [8:0] pause_req, pause_en;
    logic [47:0] gda, gsa;
    logic [143:0] rfi;
    logic [127:0] line_data, segs [0:3];
    int n_mismatch, num_checks, cycles, nseg, neop, nsmall;

    mac_tx_bus_and_pause_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .seg_data(seg_data), .seg_ena(seg_ena),
        .seg_sop(seg_sop), .seg_eop(seg_eop), .seg_err(seg_err), .seg_mty(seg_mty),
        .seg_rdy(seg_rdy), .seg_ovf(seg_ovf), .packet_small(packet_small),
        .pause_req(pause_req), .pause_en(pause_en), .global_frame_dest_addr(gda),
        .global_frame_src_addr(gsa), .global_frame_ethertype(gty), .global_frame_opcode(gop),
        .global_quanta_value(q[8]), .priority_frame_dest_addr(gsa),
        .priority_frame_src_addr(gda), .priority_frame_ethertype(gop),
        .priority_frame_opcode(gty), .prio0_quanta_value(q[0]), .prio1_quanta_value(q[1]),
        .prio2_quanta_value(q[2]), .prio3_quanta_value(q[3]), .prio4_quanta_value(q[4]),
        .prio5_quanta_value(q[5]), .prio6_quanta_value(q[6]), .prio7_quanta_value(q[7]),
        .pause_refresh_interval(rfi), .force_pause_resend(force_pause_resend),
        .line_data(line_data), .line_valid(line_valid), .line_sop(line_sop),
        .line_eop(line_eop), .line_mty(line_mty), .line_err(line_err));
    seg_source src (.pclk(pclk), .seg_rdy(seg_rdy), .seg_data(seg_data), .seg_ena(seg_ena),
        .seg_sop(seg_sop), .seg_eop(seg_eop), .seg_err(seg_err), .seg_mty(seg_mty));

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // Line monitor; counters move by non-blocking update so tasks read settled values.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (line_valid) segs[nseg[1:0]] <= line_data;
        if (line_valid) nseg <= nseg + 1;
        if (line_valid && line_eop) neop <= neop + 1;
        if (line_valid && line_eop) lmty <= line_mty;
        if (packet_small) nsmall <= nsmall + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        presetn <= 1'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_eop(input int target);
        while (neop < target) @(posedge pclk);
        @(posedge pclk);
    endtask

    task automatic t_regs();
        apb(1'h0, `ADDR_CTRL, 32'h0);
        `CHK(rd[0], `CTRL_RESET, "ctrl reset")
        apb(1'h1, `ADDR_STATUS, 32'hffff_ffff);
        apb(1'h0, `ADDR_STATUS, 32'h0);
        `CHK({err, rd[17:0]}, 19'h0, "status reset")
        apb(1'h0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'h1, 32'h0}, "unmapped")
        $display("test regs done");
    endtask

    task automatic t_small();
        int s0, e0, n0;
        s0 = nsmall;
        e0 = neop;
        n0 = nseg;
        src.pkt(20);
        wait_eop(e0 + 1);
        `CHK(nsmall - s0, 1, "small flag")
        `CHK(nseg - n0, 2, "small segments")
        `CHK(lmty, 4'hc, "small empty count")
        apb(1'h0, `ADDR_SMALLCNT, 32'h0);
        `CHK(rd[15:0], 16'h0001, "small count")
        $display("test small done");
    endtask

    // End in segment 0 and a new start in segment 1 of the same cycle.
    task automatic t_b2b();
        int s0, e0, n0;
        s0 = nsmall;
        e0 = neop;
        n0 = nseg;
        src.cyc(4'hf, 4'h1, 4'h0, 16'h0);
        src.cyc(4'hf, 4'h2, 4'h1, 16'h0);
        src.cyc(4'h3, 4'h0, 4'h2, 16'h0);
        src.idle();
        wait_eop(e0 + 2);
        `CHK({neop - e0, nseg - n0, nsmall - s0}, {32'h2, 32'ha, 32'h0}, "adjacent")
        $display("test back to back done");
    endtask

    // Buffer fills with draining off; four late writes pass, the fifth overflows.
    task automatic t_ovf();
        apb(1'h1, `ADDR_CTRL, 32'h0);
        for (int k = 0; k < 7; k++) src.cyc(4'hf, {3'h0, k == 0}, 4'h0, 16'h0);
        src.idle();
        @(posedge pclk);
        `CHK({seg_rdy, seg_ovf}, 2'h0, "late writes")
        src.cyc(4'hf, 4'h0, 4'h0, 16'h0);
        src.idle();
        @(posedge pclk);
        `CHK(seg_ovf, 1'h1, "overflow")
        apb(1'h0, `ADDR_STATUS, 32'h0);
        `CHK(rd[6:0], 7'h5c, "fill after drop")
        do_reset();
        `CHK(seg_ovf, 1'h0, "overflow after reset")
        $display("test overflow done");
    endtask

    task automatic t_gpause();
        int e0, n0;
        e0 = neop;
        n0 = nseg;
        pause_en <= `MASK_GLOBAL;
        pause_req <= `MASK_GLOBAL;
        wait_eop(e0 + 1);
        `CHK({nseg - n0, lmty}, {32'h4, 4'h0}, "pause length")
        `CHK(segs[n0 % 4], {gda, gsa, gty, gop}, "pause head")
        `CHK(segs[(n0 + 1) % 4][127:112], q[8], "global quanta")
        repeat (100) @(posedge pclk);
        `CHK(neop - e0 > 1, 1'h1, "refresh frames")
        pause_req <= 9'h000;
        repeat (20) @(posedge pclk);
        $display("test global pause done");
    endtask

    task automatic t_ppause();
        int e0, n0;
        e0 = neop;
        n0 = nseg;
        pause_en <= 9'h0ff;
        pause_req <= 9'h005;
        wait_eop(e0 + 1);
        `CHK(segs[n0 % 4], {gsa, gda, gop, gty}, "priority head")
        `CHK(segs[(n0 + 1) % 4][127:96], {16'h0005, q[0]}, "class vector")
        repeat (20) @(posedge pclk);
        force_pause_resend <= 1'h1;
        @(posedge pclk);
        force_pause_resend <= 1'h0;
        wait_eop(e0 + 2);
        `CHK(neop - e0, 2, "forced resend")
        n0 = nseg;
        pause_req <= 9'h007;
        wait_eop(e0 + 3);
        `CHK({neop - e0, segs[(n0 + 1) % 4][127:112]}, {32'h3, 16'h0007}, "merged")
        repeat (20) @(posedge pclk);
        pause_en <= 9'h000;
        repeat (20) @(posedge pclk);
        force_pause_resend <= 1'h1;
        @(posedge pclk);
        force_pause_resend <= 1'h0;
        repeat (40) @(posedge pclk);
        `CHK(neop - e0, 3, "cancelled")
        $display("test priority pause done");
    endtask

    initial begin
        {presetn, psel, penable, pwrite, force_pause_resend} = 5'h0;
        {paddr, pwdata, pause_req, pause_en} = 58'h0;
        gda = 48'h0a0b_0c0d_0e0f;
        gsa = 48'h1a2b_3c4d_5e6f;
        gty = 16'h8808;
        gop = 16'h0001;
        for (int i = 0; i < 9; i++) q[i] = {12'h100, i[3:0]};
        rfi = {16'h0030, {8{16'h0400}}};
        do_reset();
        t_regs();
        t_small();
        t_b2b();
        t_ovf();
        t_gpause();
        t_ppause();
        complete_run();
    end
endmodule
